/* design/adc_port_pkg.sv */
`default_nettype none
package adc_port_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned CONV_TIME_NS = 5300;
  localparam int unsigned CONV_CYCLES  = (CONV_TIME_NS * (CLK_HZ / 1_000_000)
                                          + 999) / 1000;
  localparam int unsigned READ_WAIT_NS = 6500;
  localparam int unsigned READ_WAIT_CYCLES =
    (READ_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned BYTE_W   = 8;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  typedef struct packed {
    logic start_select_n;
    logic start_select_alt_n;
    logic sample_start_n;
    logic chip_select_n;
    logic read_n;
    logic byte_high;
  } pins_in_s;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV} conv_state_e;
endpackage
`default_nettype wire

/* design/adc_result_host_port.sv */
`default_nettype none
module adc_result_host_port
  import adc_port_pkg::*;
#(
  parameter int unsigned CONV_CNT  = CONV_CYCLES,
  parameter bit          BYTE_MODE = 1'b0
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  input  wire pins_in_s            pins_i,
  input  wire logic [RESULT_W-1:0] sample_value_i,
  output logic                     conversion_active_n_o,
  output logic [RESULT_W-1:0]      data_o,
  output logic [RESULT_W-1:0]      data_oe_n_o
);
  typedef struct packed {
    conv_state_e           st;
    logic [15:0]           cnt;
    logic [RESULT_W-1:0]   sample;
    logic [RESULT_W-1:0]   result;
    logic                  busy_n;
    logic [RESULT_W-1:0]   dout;
    logic [RESULT_W-1:0]   oe_n;
    logic                  start_prev;
  } state_s;

  state_s   s_q, s_d;
  pins_in_s p;
  logic     start_now;
  logic     reading;

  adc_sync #(.W($bits(pins_in_s))) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (pins_i),
    .sync_o    (p)
  );

  // Any of the three start sources, edge detected
  assign start_now = !(p.start_select_n && p.start_select_alt_n
                       && p.sample_start_n);
  assign reading = !p.chip_select_n && !p.read_n;

  always_comb begin
    s_d = s_q;
    s_d.start_prev = start_now;
    case (s_q.st)
      ST_IDLE: begin
        if (start_now && !s_q.start_prev) begin
          s_d.st     = ST_CONV;
          s_d.sample = sample_value_i;
          s_d.cnt    = 16'(CONV_CNT - 1);
          s_d.busy_n = 1'b0;
        end
      end
      ST_CONV: begin
        // Restarts are ignored while busy
        if (s_q.cnt == 16'h0000) begin
          s_d.st     = ST_IDLE;
          s_d.result = s_q.sample;
          s_d.busy_n = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Data follows the result used at the busy rise
    if (reading) begin
      if (BYTE_MODE) begin
        s_d.dout = {8'h00, p.byte_high ? s_d.result[15:8]
                                       : s_d.result[7:0]};
        s_d.oe_n = {8'hff, 8'h00};
      end else begin
        s_d.dout = s_d.result;
        s_d.oe_n = 16'h0000;
      end
    end else begin
      s_d.dout = 16'h0000;
      s_d.oe_n = 16'hffff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_q <= '{st: ST_IDLE, cnt: 16'h0000, sample: RESULT_RST,
               result: RESULT_RST, busy_n: 1'b1, dout: 16'h0000,
               oe_n: 16'hffff, start_prev: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign conversion_active_n_o = s_q.busy_n;
  assign data_o                = s_q.dout;
  assign data_oe_n_o           = s_q.oe_n;

  property p_busy_rise;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(s_q.busy_n) |-> s_q.result == $past(s_q.sample);
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("bad result");

  property p_busy_len;
    @(posedge ref_clk_i) disable iff (rst_i)
      $fell(s_q.busy_n) |-> !s_q.busy_n [*8];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("short busy");

  property p_word;
    @(posedge ref_clk_i) disable iff (rst_i)
      (!BYTE_MODE && reading) |=> data_o == s_q.result;
  endproperty
  a_word: assert property (p_word) else $error("word data wrong");

  property p_byte;
    @(posedge ref_clk_i) disable iff (rst_i)
      (BYTE_MODE && reading && p.byte_high) |=>
        data_o[7:0] == s_q.result[15:8];
  endproperty
  a_byte: assert property (p_byte) else $error("high byte wrong");

  property p_standalone;
    @(posedge ref_clk_i) disable iff (rst_i)
      ($rose(s_q.busy_n) && $past(reading) && !BYTE_MODE) |->
        data_o == s_q.result;
  endproperty
  a_standalone: assert property (p_standalone) else $error("not valid");

  property p_take;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s_q.st == ST_IDLE && start_now && !s_q.start_prev) |=>
        (!s_q.busy_n && s_q.sample == $past(sample_value_i));
  endproperty
  a_take: assert property (p_take)
    else $error("start not taken");

  property p_no_start;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s_q.st == ST_IDLE && !(start_now && !s_q.start_prev)) |=>
        s_q.busy_n;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("spurious start");

  property p_conv_low;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s_q.st == ST_CONV) |-> !s_q.busy_n;
  endproperty
  a_conv_low: assert property (p_conv_low)
    else $error("busy high during conversion");

  property p_idle_high;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s_q.st == ST_IDLE) |-> s_q.busy_n;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("busy low while idle");

  property p_cnt_load;
    @(posedge ref_clk_i) disable iff (rst_i)
      $fell(s_q.busy_n) |-> s_q.cnt == 16'(CONV_CNT - 1);
  endproperty
  a_cnt_load: assert property (p_cnt_load)
    else $error("conversion count not loaded");

  property p_cnt_step;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s_q.st == ST_CONV && s_q.cnt != 16'h0000) |=>
        (s_q.st == ST_CONV && s_q.cnt == $past(s_q.cnt) - 16'h0001);
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("conversion count skipped");

  property p_cnt_end;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s_q.st == ST_CONV && s_q.cnt == 16'h0000) |=> $rose(s_q.busy_n);
  endproperty
  a_cnt_end: assert property (p_cnt_end)
    else $error("busy did not rise at count end");

  property p_sample_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s_q.st == ST_CONV) |=> $stable(s_q.sample);
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("sample changed during conversion");

  property p_result_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      !$rose(s_q.busy_n) |-> $stable(s_q.result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed away from busy rise");

  property p_word_oe;
    @(posedge ref_clk_i) disable iff (rst_i)
      (!BYTE_MODE && reading) |=> data_oe_n_o == 16'h0000;
  endproperty
  a_word_oe: assert property (p_word_oe)
    else $error("word bus not driven");

  property p_byte_low;
    @(posedge ref_clk_i) disable iff (rst_i)
      (BYTE_MODE && reading && !p.byte_high) |=>
        data_o[7:0] == s_q.result[7:0];
  endproperty
  a_byte_low: assert property (p_byte_low)
    else $error("low byte wrong");

  property p_byte_oe;
    @(posedge ref_clk_i) disable iff (rst_i)
      (BYTE_MODE && reading) |=>
        (data_oe_n_o == 16'hff00 && data_o[15:8] == 8'h00);
  endproperty
  a_byte_oe: assert property (p_byte_oe)
    else $error("byte bus enable wrong");

  property p_release;
    @(posedge ref_clk_i) disable iff (rst_i)
      !reading |=> (data_oe_n_o == 16'hffff && data_o == 16'h0000);
  endproperty
  a_release: assert property (p_release)
    else $error("bus not released");
endmodule
`default_nettype wire

/* design/adc_sync.sv */
`default_nettype none
module adc_sync #(
  parameter int unsigned W = 6
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      sync_o <= '1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* tb/host_latch.sv */
`default_nettype none
module host_latch
  import adc_port_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                conv_active_n_i,
  input  wire logic [RESULT_W-1:0] data_i,
  output logic      [RESULT_W-1:0] latch_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_n_q = 1'b1;
  // Output latch clocked by ref_clk_i, loaded on busy rise
  always_ff @(posedge ref_clk_i) begin
    busy_n_q <= conv_active_n_i;
    if (conv_active_n_i && !busy_n_q) latch_o <= data_i;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
module tb_top import adc_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CC = 10;
  logic        ref_clk_i = 0;
  logic        rst_i = 1;
  pins_in_s    pins = '1;
  logic [15:0] smp = '0, ev, wd, bd, wl, woe, boe;
  logic        wb;
  int          num_errors = 0, samples_checked = 0, cyc = 0, n;
  adc_result_host_port #(.CONV_CNT(CC)) adc_result_host_port_i (
    .ref_clk_i, .rst_i, .pins_i(pins), .sample_value_i(smp),
    .conversion_active_n_o(wb), .data_o(wd), .data_oe_n_o(woe));
  adc_result_host_port #(.CONV_CNT(CC), .BYTE_MODE(1'b1)) byte_port_i (
    .ref_clk_i, .rst_i, .pins_i(pins), .sample_value_i(smp),
    .conversion_active_n_o(), .data_o(bd), .data_oe_n_o(boe));
  host_latch host_latch_i (.ref_clk_i, .conv_active_n_i(wb),
    .data_i(wd), .latch_o(wl));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [15:0] exp_byte(input logic [15:0] r,
                                           input logic        hi);
    return {8'h00, hi ? r[15:8] : r[7:0]};
  endfunction
  task automatic chk(input logic [15:0] a, input logic [15:0] b);
    samples_checked++;
    if (a !== b) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, a, b);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    void'($urandom(32'hc0d9));
    tick(12);
    rst_i = 0;
    chk(woe, 16'hffff);
    for (int i = 0; i < 9; i++) begin
      smp = i == 0 ? 16'hffff : i == 1 ? 16'h8000 : 16'($urandom);
      ev = smp;
      pins.chip_select_n = 0;
      pins.read_n = 0;
      pins.byte_high = 1;
      pins[5:3] = ~(3'b100 >> (i % 3));
      tick(2);
      pins[5:3] = '1;
      n = 0;
      while (wb !== 1'b0 && n < 8) begin tick(1); n++; end
      // Restart and new sample during busy must not disturb
      pins.sample_start_n = 0;
      smp = ~smp;
      tick(2);
      pins.sample_start_n = 1;
      n = 2;
      while (wb !== 1'b1 && n < 40) begin tick(1); n++; end
      chk(16'(n), 16'(CC));
      chk(wd, ev);
      chk(woe, 16'h0000);
      chk(bd, exp_byte(ev, 1'b1));
      chk(boe, 16'hff00);
      tick(1);
      chk(wl, ev);
      pins.byte_high = 0;
      tick(4);
      chk(bd, exp_byte(ev, 1'b0));
      pins.read_n = 1;
      tick(4);
      chk(woe, 16'hffff);
      chk(wd, 16'h0000);
    end
    // Reset in mid conversion must leave the port idle
    pins.chip_select_n = 1;
    pins.sample_start_n = 0;
    tick(4);
    pins.sample_start_n = 1;
    rst_i = 1;
    tick(2);
    rst_i = 0;
    chk({15'h0, wb}, 16'h0001);
    chk(woe, 16'hffff);
    // Reads after completion: k=0 watches busy, k=1 waits blind
    for (int k = 0; k < 2; k++) begin
      smp = 16'($urandom);
      ev = smp;
      pins.start_select_alt_n = 0;
      tick(2);
      pins.start_select_alt_n = 1;
      tick(1);
      n = 0;
      if (k == 0) begin
        while (wb !== 1'b1 && n < 40) begin
          chk(woe, 16'hffff);
          tick(1);
          n++;
        end
        chk(16'(n), 16'(CC));
      end else begin
        tick(int'(READ_WAIT_CYCLES) - 3);
        chk({15'h0, wb}, 16'h0001);
      end
      pins.chip_select_n = 0;
      pins.read_n = 0;
      pins.byte_high = 1;
      tick(4);
      chk(wd, ev);
      chk(woe, 16'h0000);
      chk(bd, exp_byte(ev, 1'b1));
      chk(boe, 16'hff00);
      pins.byte_high = 0;
      tick(4);
      chk(bd, exp_byte(ev, 1'b0));
      pins.chip_select_n = 1;
      pins.read_n = 1;
      tick(4);
      chk(woe, 16'hffff);
      chk(boe, 16'hffff);
    end
    close_out();
  end
endmodule
`default_nettype wire
